// ===== bench/lshc_plant.sv
// far-side model: heater current sensing that strobes samples into the bank
`timescale 1ns/100ps

module lshc_plant (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [1:0]       sample,
  input  wire logic [1:0][15:0] level,
  output logic      [1:0]       meas_valid,
  output logic      [1:0][15:0] meas_current
);
  // ----------------------------------------------------------------
  // sample strobe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_valid   <= 2'b00;
      meas_current <= '0;
    end else begin
      meas_valid <= sample;
      for (int i = 0; i < 2; i++) begin
        // value not held outside a strobe, toggles to expose stale loads
        meas_current[i] <= sample[i] ? level[i] : ~meas_current[i];
      end
    end
  end
endmodule // lshc_plant

// ===== bench/tb.sv
// self-checking bench for the loop status and heater current bank
`timescale 1ns/100ps

module tb;
  logic             core_clk;
  logic             rst_n;
  logic             wr_en;
  logic             rd_en;
  logic [4:0]       addr;
  logic [15:0]      wdata;
  logic [15:0]      rdata;
  logic             rd_valid;
  logic [1:0]       loop_running;
  logic [1:0]       ctrl_out_on;
  logic [1:0]       autotune_running;
  logic [1:0]       first_alarm_in_range;
  logic [1:0]       second_alarm_in_range;
  logic [1:0]       meas_valid;
  logic [1:0][15:0] meas_current;
  logic [1:0]       heater_burnout_out;
  logic [15:0]      rdata_bcd;
  logic             rd_valid_bcd;
  logic [1:0]       heater_burnout_bcd;
  logic [1:0]       sample;
  logic [1:0][15:0] level;
  int               num_errors;
  int               check_count;
  logic [4:0]       quiet_ofs [5] = '{5'h0c, 5'h0f, 5'h11, 5'h12, 5'h13};

  lshc_bank i_lshc_bank (
    .core_clk              (core_clk),
    .rst_n                 (rst_n),
    .wr_en                 (wr_en),
    .rd_en                 (rd_en),
    .addr                  (addr),
    .wdata                 (wdata),
    .rdata                 (rdata),
    .rd_valid              (rd_valid),
    .loop_running          (loop_running),
    .ctrl_out_on           (ctrl_out_on),
    .autotune_running      (autotune_running),
    .first_alarm_in_range  (first_alarm_in_range),
    .second_alarm_in_range (second_alarm_in_range),
    .meas_valid            (meas_valid),
    .meas_current          (meas_current),
    .heater_burnout_out    (heater_burnout_out)
  );

  lshc_plant i_lshc_plant (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .sample       (sample),
    .level        (level),
    .meas_valid   (meas_valid),
    .meas_current (meas_current)
  );

  // second bank in bcd mode shares the bus, the flags and the plant
  lshc_bank #(
    .USE_BCD (1'b1)
  ) i_lshc_bank_bcd (
    .core_clk              (core_clk),
    .rst_n                 (rst_n),
    .wr_en                 (wr_en),
    .rd_en                 (rd_en),
    .addr                  (addr),
    .wdata                 (wdata),
    .rdata                 (rdata_bcd),
    .rd_valid              (rd_valid_bcd),
    .loop_running          (loop_running),
    .ctrl_out_on           (ctrl_out_on),
    .autotune_running      (autotune_running),
    .first_alarm_in_range  (first_alarm_in_range),
    .second_alarm_in_range (second_alarm_in_range),
    .meas_valid            (meas_valid),
    .meas_current          (meas_current),
    .heater_burnout_out    (heater_burnout_bcd)
  );

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge core_clk);
    #1;
    wr_en = 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    #1;
    rd_en = 1'b1;
    addr  = a;
    @(posedge core_clk);
    #1;
    rd_en = 1'b0;
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rdata, exp);
  endtask

  // write then read back on the very next edge
  task automatic wr_rd(input logic [4:0] wa, input logic [15:0] d, input logic [4:0] ra);
    @(posedge core_clk);
    #1;
    wr_en = 1'b1;
    addr  = wa;
    wdata = d;
    @(posedge core_clk);
    #1;
    wr_en = 1'b0;
    rd_en = 1'b1;
    addr  = ra;
    @(posedge core_clk);
    #1;
    rd_en = 1'b0;
    chk({15'h0000, rd_valid}, 16'h0001);
    chk(rdata, d);
  endtask

  // sample goes to the plant, the bank loads it one edge later
  task automatic meas(input int lp, input logic [15:0] v);
    @(posedge core_clk);
    #1;
    sample[lp] = 1'b1;
    level[lp]  = v;
    @(posedge core_clk);
    #1;
    sample[lp] = 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic flags(input logic [1:0] run, input logic [1:0] other, input logic [1:0] al2);
    loop_running          = run;
    ctrl_out_on           = other;
    autotune_running      = other;
    first_alarm_in_range  = other;
    second_alarm_in_range = al2;
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    sample = 2'b00;
    level = '0;
    num_errors = 0;
    check_count = 0;
    {loop_running, ctrl_out_on, autotune_running} = 6'h00;
    {first_alarm_in_range, second_alarm_in_range} = 4'h0;
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h0100);
    chk({14'h0000, heater_burnout_out}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(quiet_ofs[i], 16'hffff);
      rd_chk(quiet_ofs[i], 16'h0000);
    end
    flags(2'b01, 2'b01, 2'b10);
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h001a);
    rd_chk(lshc_pkg::STATUS_LOOP2_OFS, 16'h0101);
    flags(2'b10, 2'b10, 2'b01);
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h0101);
    rd_chk(lshc_pkg::STATUS_LOOP2_OFS, 16'h001a);
    flags(2'b11, 2'b00, 2'b00);
    wr(lshc_pkg::BURNOUT_THR_LOOP1_OFS, 16'h012c);
    wr(lshc_pkg::BURNOUT_THR_LOOP2_OFS, lshc_pkg::THR_DISABLE);
    rd_chk(lshc_pkg::BURNOUT_THR_LOOP1_OFS, 16'h012c);
    rd_chk(lshc_pkg::ACTIVE_THR_LOOP1_OFS, 16'h012c);
    meas(0, 16'h012c);
    chk({14'h0000, heater_burnout_out}, 16'h0001);
    rd_chk(lshc_pkg::CURRENT_LOOP1_OFS, 16'h012c);
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h0004);
    meas(0, 16'h012b);
    chk({14'h0000, heater_burnout_out}, 16'h0000);
    meas(1, 16'h0190);
    chk({14'h0000, heater_burnout_out}, 16'h0000);
    rd_chk(lshc_pkg::CURRENT_LOOP2_OFS, 16'h0190);
    chk(rdata_bcd, 16'h0400);
    chk({15'h0000, rd_valid_bcd}, 16'h0001);
    wr_rd(lshc_pkg::BURNOUT_THR_LOOP2_OFS, lshc_pkg::THR_TEST,
          lshc_pkg::ACTIVE_THR_LOOP2_OFS);
    repeat (3) @(posedge core_clk);
    #1;
    chk({14'h0000, heater_burnout_out}, 16'h0002);
    rd_chk(lshc_pkg::ACTIVE_THR_LOOP2_OFS, 16'h01f4);
    rd_chk(lshc_pkg::STATUS_LOOP2_OFS, 16'h0004);
    meas(0, 16'h0227);
    rd_chk(lshc_pkg::CURRENT_LOOP1_OFS, lshc_pkg::OVERFLOW_CODE);
    chk(rdata_bcd, lshc_pkg::OVERFLOW_CODE);
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h2004);
    meas(0, 16'h0226);
    rd_chk(lshc_pkg::CURRENT_LOOP1_OFS, 16'h0226);
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h0004);
    // control output and autotune apart, so a swapped bit shows
    ctrl_out_on      = 2'b10;
    autotune_running = 2'b01;
    repeat (5) @(posedge core_clk);
    #1;
    rd_chk(lshc_pkg::STATUS_LOOP1_OFS, 16'h000c);
    rd_chk(lshc_pkg::STATUS_LOOP2_OFS, 16'h0014);
    // 50.0 in bcd is the test value only for the bcd bank
    wr(lshc_pkg::BURNOUT_THR_LOOP1_OFS, 16'h0500);
    repeat (2) @(posedge core_clk);
    #1;
    chk({14'h0000, heater_burnout_out}, 16'h0002);
    chk({14'h0000, heater_burnout_bcd}, 16'h0003);
    test_done();
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
endmodule // tb

// ===== inc/lshc_pkg.sv
// constants for the loop status and heater current word bank
package lshc_pkg;

  // ----------------------------------------------------------------
  // word offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] STATUS_LOOP1_OFS      = 5'h08;
  localparam logic [4:0] STATUS_LOOP2_OFS      = 5'h09;
  localparam logic [4:0] BURNOUT_THR_LOOP1_OFS = 5'h0a;
  localparam logic [4:0] BURNOUT_THR_LOOP2_OFS = 5'h0b;
  localparam logic [4:0] RESERVED_A_OFS        = 5'h0c;
  localparam logic [4:0] CURRENT_LOOP1_OFS     = 5'h0d;
  localparam logic [4:0] CURRENT_LOOP2_OFS     = 5'h0e;
  localparam logic [4:0] ACTIVE_THR_LOOP1_OFS  = 5'h0f;
  localparam logic [4:0] ACTIVE_THR_LOOP2_OFS  = 5'h10;
  localparam logic [4:0] RESERVED_B_OFS        = 5'h11;
  localparam logic [4:0] RESERVED_C_OFS        = 5'h12;
  localparam logic [4:0] RESERVED_D_OFS        = 5'h13;

  // ----------------------------------------------------------------
  // status word bit positions
  // ----------------------------------------------------------------
  localparam int SECOND_ALARM_BIT  = 0;
  localparam int FIRST_ALARM_BIT   = 1;
  localparam int BURNOUT_BIT       = 2;
  localparam int AUTOTUNE_BIT      = 3;
  localparam int CTRL_OUT_BIT      = 4;
  localparam int STOP_BIT          = 8;
  localparam int OVERFLOW_BIT      = 13;

  // ----------------------------------------------------------------
  // sync vector bit positions (per loop)
  // ----------------------------------------------------------------
  localparam int IN_RUN_BIT = 0;
  localparam int IN_CTRL_BIT = 1;
  localparam int IN_AT_BIT = 2;
  localparam int IN_AL1_BIT = 3;
  localparam int IN_AL2_BIT = 4;

  // ----------------------------------------------------------------
  // values in tenths of an ampere, and the overflow code
  // ----------------------------------------------------------------
  localparam logic [15:0] THR_DISABLE    = 16'h0000;
  localparam logic [15:0] THR_TEST       = 16'h01f4;
  localparam logic [15:0] CURRENT_LIMIT  = 16'h0226;
  localparam logic [15:0] OVERFLOW_CODE  = 16'hcccc;
  localparam logic [15:0] WORD_RESET     = 16'h0000;

endpackage

// ===== verilog/lshc_bank.sv
// loop status flags and heater burnout / heater current word bank
`timescale 1ns/100ps

// Operation
// - stop flag high when regulation halted
// - reserved bits and words read zero
// - control output flag follows control output
// - autotune flag high during autotuning
// - burnout when current reaches threshold
// - alarm flags high inside alarm range
// - zero threshold disables burnout detection
// - test threshold forces burnout output on
// - heater current reported per loop word
// - over limit sets overflow, code cccc
// - active threshold read back per loop
// - overflow flag at status bit 13
module lshc_bank #(
  parameter bit USE_BCD = 1'b0
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [4:0]        addr,
  input  wire logic [15:0]       wdata,
  output logic      [15:0]       rdata,
  output logic                   rd_valid,
  input  wire logic [1:0]        loop_running,
  input  wire logic [1:0]        ctrl_out_on,
  input  wire logic [1:0]        autotune_running,
  input  wire logic [1:0]        first_alarm_in_range,
  input  wire logic [1:0]        second_alarm_in_range,
  input  wire logic [1:0]        meas_valid,
  input  wire logic [1:0][15:0]  meas_current,
  output logic      [1:0]        heater_burnout_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0][4:0]  sync1;
    logic [1:0][4:0]  sync2;
    logic [1:0][15:0] thr;
    logic [1:0][15:0] cur;
    logic [1:0]       stop;
    logic [1:0]       ctrl;
    logic [1:0]       at;
    logic [1:0]       al1;
    logic [1:0]       al2;
    logic [1:0]       hb;
    logic [1:0]       ovf;
    logic [15:0]      rdata;
    logic             rd_valid;
  } lshc_state_t;

  lshc_state_t q;
  lshc_state_t next_q;

  logic [1:0][4:0]  raw_in;
  logic [1:0][15:0] thr_bin;
  logic [1:0][15:0] cur_word;
  logic [1:0][15:0] stat_word;

  // ----------------------------------------------------------------
  // encoding helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] to_bcd(input logic [15:0] v);
    logic [31:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (s[16+4*d +: 4] >= 4'h5) begin
          s[16+4*d +: 4] = s[16+4*d +: 4] + 4'h3;
        end
      end
      s = {s[30:0], 1'b0};
    end
    return s[31:16];
  endfunction

  function automatic logic [15:0] to_bin(input logic [15:0] v);
    logic [15:0] r;
    r = 16'(16'({12'h000, v[15:12]}) * 16'd1000);
    r = 16'(r + 16'({12'h000, v[11:8]}) * 16'd100);
    r = 16'(r + 16'({12'h000, v[7:4]}) * 16'd10);
    r = 16'(r + {12'h000, v[3:0]});
    return r;
  endfunction

  // ----------------------------------------------------------------
  // per-loop decode
  // ----------------------------------------------------------------
  // one parameter picks the encoding for the threshold and current words
  for (genvar g = 0; g < 2; g++) begin : g_loop
    assign raw_in[g] = {second_alarm_in_range[g], first_alarm_in_range[g],
                        autotune_running[g], ctrl_out_on[g], loop_running[g]};
    assign thr_bin[g] = USE_BCD ? to_bin(q.thr[g]) : q.thr[g];
    // bcd reports cannot exceed 9999 tenths, the limit keeps us well below
    assign cur_word[g] = q.ovf[g] ? lshc_pkg::OVERFLOW_CODE :
                         (USE_BCD ? to_bcd(q.cur[g]) : q.cur[g]);
    always_comb begin
      stat_word[g] = 16'h0000;
      stat_word[g][lshc_pkg::SECOND_ALARM_BIT] = q.al2[g];
      stat_word[g][lshc_pkg::FIRST_ALARM_BIT] = q.al1[g];
      stat_word[g][lshc_pkg::BURNOUT_BIT] = q.hb[g];
      stat_word[g][lshc_pkg::AUTOTUNE_BIT] = q.at[g];
      stat_word[g][lshc_pkg::CTRL_OUT_BIT] = q.ctrl[g];
      stat_word[g][lshc_pkg::STOP_BIT] = q.stop[g];
      stat_word[g][lshc_pkg::OVERFLOW_BIT] = q.ovf[g];
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.sync1 = raw_in;
    next_q.sync2 = q.sync1;
    for (int i = 0; i < 2; i++) begin
      next_q.stop[i] = !q.sync2[i][lshc_pkg::IN_RUN_BIT];
      next_q.ctrl[i] = q.sync2[i][lshc_pkg::IN_CTRL_BIT];
      next_q.at[i] = q.sync2[i][lshc_pkg::IN_AT_BIT];
      next_q.al1[i] = q.sync2[i][lshc_pkg::IN_AL1_BIT];
      next_q.al2[i] = q.sync2[i][lshc_pkg::IN_AL2_BIT];
      if (meas_valid[i]) begin
        next_q.cur[i] = meas_current[i];
      end
      next_q.ovf[i] = q.cur[i] > lshc_pkg::CURRENT_LIMIT;
      if (thr_bin[i] == lshc_pkg::THR_DISABLE) begin
        next_q.hb[i] = 1'b0;
      end else if (thr_bin[i] == lshc_pkg::THR_TEST) begin
        next_q.hb[i] = 1'b1;
      end else begin
        next_q.hb[i] = q.cur[i] >= thr_bin[i];
      end
    end
    // host words are taken whole; reserved words ignore writes
    if (wr_en) begin
      unique case (addr)
        lshc_pkg::BURNOUT_THR_LOOP1_OFS: next_q.thr[0] = wdata;
        lshc_pkg::BURNOUT_THR_LOOP2_OFS: next_q.thr[1] = wdata;
        default: next_q.thr = q.thr;
      endcase
    end
    next_q.rd_valid = rd_en;
    next_q.rdata = 16'h0000;
    if (rd_en) begin
      unique case (addr)
        lshc_pkg::STATUS_LOOP1_OFS:      next_q.rdata = stat_word[0];
        lshc_pkg::STATUS_LOOP2_OFS:      next_q.rdata = stat_word[1];
        lshc_pkg::BURNOUT_THR_LOOP1_OFS: next_q.rdata = q.thr[0];
        lshc_pkg::BURNOUT_THR_LOOP2_OFS: next_q.rdata = q.thr[1];
        lshc_pkg::CURRENT_LOOP1_OFS:     next_q.rdata = cur_word[0];
        lshc_pkg::CURRENT_LOOP2_OFS:     next_q.rdata = cur_word[1];
        lshc_pkg::ACTIVE_THR_LOOP1_OFS:  next_q.rdata = q.thr[0];
        lshc_pkg::ACTIVE_THR_LOOP2_OFS:  next_q.rdata = q.thr[1];
        default:                         next_q.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.sync1 <= '0;
      q.sync2 <= '0;
      q.thr <= {lshc_pkg::WORD_RESET, lshc_pkg::WORD_RESET};
      q.cur <= {lshc_pkg::WORD_RESET, lshc_pkg::WORD_RESET};
      q.stop <= 2'h3;
      q.ctrl <= 2'h0;
      q.at <= 2'h0;
      q.al1 <= 2'h0;
      q.al2 <= 2'h0;
      q.hb <= 2'h0;
      q.ovf <= 2'h0;
      q.rdata <= lshc_pkg::WORD_RESET;
      q.rd_valid <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = q.rdata;
  assign rd_valid = q.rd_valid;
  assign heater_burnout_out = q.hb;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_chk
    sequence s_run_held;
      q.sync2[g][lshc_pkg::IN_RUN_BIT] ##1 1'b1;
    endsequence

    property p_stop;
      @(posedge core_clk) disable iff (!rst_n)
        s_run_held |-> !q.stop[g];
    endproperty
    a_stop: assert property (p_stop)
      else $error("stop flag set while loop runs");

    property p_ctrl;
      @(posedge core_clk) disable iff (!rst_n)
        $rose(q.sync2[g][lshc_pkg::IN_CTRL_BIT]) |=> q.ctrl[g] && !$past(q.ctrl[g]);
    endproperty
    a_ctrl: assert property (p_ctrl)
      else $error("control output flag missed rise");

    property p_at;
      @(posedge core_clk) disable iff (!rst_n)
        q.sync2[g][lshc_pkg::IN_AT_BIT] [*2] |=> q.at[g] && $past(q.at[g]);
    endproperty
    a_at: assert property (p_at)
      else $error("autotune flag dropped during run");

    property p_alarm;
      @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> (q.al1[g] == $past(q.sync2[g][lshc_pkg::IN_AL1_BIT]))
              && (q.al2[g] == $past(q.sync2[g][lshc_pkg::IN_AL2_BIT]));
    endproperty
    a_alarm: assert property (p_alarm)
      else $error("alarm flag does not follow range input");

    property p_hb;
      @(posedge core_clk) disable iff (!rst_n)
        (thr_bin[g] != lshc_pkg::THR_DISABLE) && (q.cur[g] >= thr_bin[g])
          |=> heater_burnout_out[g];
    endproperty
    a_hb: assert property (p_hb)
      else $error("burnout not flagged at threshold");

    property p_hb_off;
      @(posedge core_clk) disable iff (!rst_n)
        (thr_bin[g] == lshc_pkg::THR_DISABLE) |=> !q.hb[g];
    endproperty
    a_hb_off: assert property (p_hb_off)
      else $error("burnout flagged with zero threshold");

    property p_hb_test;
      @(posedge core_clk) disable iff (!rst_n)
        (thr_bin[g] == lshc_pkg::THR_TEST) [*2] |=> heater_burnout_out[g] [*1];
    endproperty
    a_hb_test: assert property (p_hb_test)
      else $error("test threshold did not force burnout");

    property p_ovf;
      @(posedge core_clk) disable iff (!rst_n)
        (q.cur[g] > lshc_pkg::CURRENT_LIMIT) |=> q.ovf[g]
          && (cur_word[g] == lshc_pkg::OVERFLOW_CODE) && stat_word[g][13];
    endproperty
    a_ovf: assert property (p_ovf)
      else $error("overflow not reported");

    property p_stop_halt;
      @(posedge core_clk) disable iff (!rst_n)
        !q.sync2[g][lshc_pkg::IN_RUN_BIT] |=> q.stop[g];
    endproperty
    a_stop_halt: assert property (p_stop_halt)
      else $error("stop flag clear while loop halted");

    property p_ctrl_off;
      @(posedge core_clk) disable iff (!rst_n)
        !q.sync2[g][lshc_pkg::IN_CTRL_BIT] |=> !q.ctrl[g];
    endproperty
    a_ctrl_off: assert property (p_ctrl_off)
      else $error("control output flag set while output off");

    property p_at_off;
      @(posedge core_clk) disable iff (!rst_n)
        !q.sync2[g][lshc_pkg::IN_AT_BIT] |=> !q.at[g];
    endproperty
    a_at_off: assert property (p_at_off)
      else $error("autotune flag set outside a run");

    property p_hb_below;
      @(posedge core_clk) disable iff (!rst_n)
        (thr_bin[g] != lshc_pkg::THR_DISABLE) && (thr_bin[g] != lshc_pkg::THR_TEST)
          && (q.cur[g] < thr_bin[g]) |=> !heater_burnout_out[g];
    endproperty
    a_hb_below: assert property (p_hb_below)
      else $error("burnout flagged below threshold");

    property p_ovf_off;
      @(posedge core_clk) disable iff (!rst_n)
        (q.cur[g] <= lshc_pkg::CURRENT_LIMIT)
          |=> !q.ovf[g] && !stat_word[g][lshc_pkg::OVERFLOW_BIT];
    endproperty
    a_ovf_off: assert property (p_ovf_off)
      else $error("overflow flag set within limit");
  end

  property p_rd_cur;
    @(posedge core_clk) disable iff (!rst_n)
      rd_en && (addr == lshc_pkg::CURRENT_LOOP1_OFS)
        |=> rd_valid && (rdata == $past(cur_word[0]));
  endproperty
  a_rd_cur: assert property (p_rd_cur)
    else $error("current word read wrong");

  property p_rd_thr;
    @(posedge core_clk) disable iff (!rst_n)
      wr_en && (addr == lshc_pkg::BURNOUT_THR_LOOP2_OFS) ##1
        rd_en && (addr == lshc_pkg::ACTIVE_THR_LOOP2_OFS)
        |=> rdata == $past(wdata, 2);
  endproperty
  a_rd_thr: assert property (p_rd_thr)
    else $error("active threshold readback wrong");

  property p_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      rd_en && ((addr == lshc_pkg::RESERVED_A_OFS) || (addr == lshc_pkg::RESERVED_B_OFS)
        || (addr == lshc_pkg::RESERVED_C_OFS) || (addr == lshc_pkg::RESERVED_D_OFS))
        |=> rdata == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved word not zero");

  property p_stat_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      rd_en && (addr == lshc_pkg::STATUS_LOOP1_OFS)
        |=> (rdata[7:5] == 3'h0) && (rdata[15:14] == 2'h0) && (rdata[12:9] == 4'h0);
  endproperty
  a_stat_rsvd: assert property (p_stat_rsvd)
    else $error("reserved status bits not zero");

  property p_thr_wr;
    @(posedge core_clk) disable iff (!rst_n)
      wr_en && (addr == lshc_pkg::BURNOUT_THR_LOOP1_OFS) |=> q.thr[0] == $past(wdata);
  endproperty
  a_thr_wr: assert property (p_thr_wr)
    else $error("threshold write did not land");

  property p_stat2_rsvd;
    @(posedge core_clk) disable iff (!rst_n)
      rd_en && (addr == lshc_pkg::STATUS_LOOP2_OFS)
        |=> (rdata[7:5] == 3'h0) && (rdata[15:14] == 2'h0) && (rdata[12:9] == 4'h0);
  endproperty
  a_stat2_rsvd: assert property (p_stat2_rsvd)
    else $error("reserved status bits of loop two not zero");

endmodule // lshc_bank
